// ### common/query_pkg.sv
// Package of register addresses, selectors, sizes and reset values for the query readback block
package query_pkg;

  // ***************************************************************
  // Register addresses
  // ***************************************************************
  localparam logic [7:0] ADDR_QUERY_FIRST = 8'h20;
  localparam logic [7:0] ADDR_IDENTITY_QUERY = 8'h23;
  localparam logic [7:0] ADDR_LIST_POINT_QUERY = 8'h24;
  localparam logic [7:0] ADDR_LEVEL_DAC_QUERY = 8'h25;
  localparam logic [7:0] ADDR_SPI_READOUT_BUFFER = 8'h26;

  // ***************************************************************
  // USB endpoints and limits
  // ***************************************************************
  localparam logic [7:0] INTERRUPT_IN_ENDPOINT = 8'h81;
  localparam logic [7:0] INTERRUPT_OUT_ENDPOINT = 8'h02;
  localparam logic [7:0] BULK_IN_ENDPOINT = 8'h83;
  localparam logic [7:0] BULK_OUT_ENDPOINT = 8'h04;
  localparam int USB_MAX_TRANSFER_BYTES = 64;
  localparam int USB_FULL_SPEED_MBPS = 12;

  // ***************************************************************
  // Command framing
  // ***************************************************************
  localparam int CMD_MIN_BYTES = 2;
  localparam int CMD_MAX_BYTES = 6;
  localparam int RESULT_BYTES = 5;
  localparam logic [2:0] CNT_RESET = 3'h0;
  localparam logic [2:0] RESULT_BYTES_CNT = 3'h5;

  // ***************************************************************
  // Identity selectors and field positions
  // ***************************************************************
  localparam logic [2:0] SEL_SERIAL = 3'h0;
  localparam logic [2:0] SEL_HW_REV = 3'h1;
  localparam logic [2:0] SEL_FW_REV = 3'h2;
  localparam logic [2:0] SEL_MFG_DATE = 3'h3;
  localparam int IDENT_LSB = 8;
  localparam int DAC_LSB = 24;
  localparam int LIST_POINTS = 2048;
  localparam logic [10:0] LIST_LAST_INDEX = 11'h7FF;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [39:0] RESULT_RESET = 40'h00_0000_0000;

endpackage

// ### tb/host_model.sv
// Host model that drives USB bulk and SPI command bytes
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input wire logic sys_clk_i,
  // USB
  output var logic usb_cmd_valid_o = 1'b0,
  output var logic [7:0] usb_cmd_byte_o = 8'h00,
  output var logic usb_cmd_last_o = 1'b0,
  output var logic [7:0] usb_cmd_endpoint_o = 8'h00,
  output var logic usb_rd_req_o = 1'b0,
  // SPI
  output var logic spi_frame_o = 1'b0,
  output var logic spi_byte_valid_o = 1'b0,
  output var logic [7:0] spi_byte_o = 8'h00
);
  // ***********************
  // Transfers
  // ***********************
  // Address byte then n data bytes, MSB first; idle byte lines toggle
  task automatic usb_cmd(input logic [7:0] ep, input logic [7:0] adr, input logic [39:0] d, input int n);
    @(posedge sys_clk_i);
    #1;
    usb_cmd_endpoint_o = ep;
    usb_cmd_valid_o = 1'b1;
    usb_cmd_byte_o = adr;
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge sys_clk_i);
      #1;
      usb_cmd_byte_o = d[8*i+:8];
      usb_cmd_last_o = (i == 0);
    end
    @(posedge sys_clk_i);
    #1;
    usb_cmd_valid_o = 1'b0;
    usb_cmd_last_o = 1'b0;
    usb_cmd_byte_o = ~usb_cmd_byte_o;
    usb_cmd_endpoint_o = ~usb_cmd_endpoint_o;
  endtask

  task automatic usb_read();
    @(posedge sys_clk_i);
    #1;
    usb_rd_req_o = 1'b1;
    @(posedge sys_clk_i);
    #1;
    usb_rd_req_o = 1'b0;
  endtask

  task automatic spi_byte(input logic [7:0] b);
    @(posedge sys_clk_i);
    #1;
    spi_byte_valid_o = 1'b1;
    spi_byte_o = b;
    @(posedge sys_clk_i);
    #1;
    spi_byte_valid_o = 1'b0;
    spi_byte_o = ~b;
  endtask

  // Readout callers pass all-zero data of five bytes
  task automatic spi_cmd(input logic [7:0] adr, input logic [39:0] d, input int n);
    @(posedge sys_clk_i);
    #1;
    spi_frame_o = 1'b1;
    spi_byte(adr);
    for (int i = n - 1; i >= 0; i--) spi_byte(d[8*i+:8]);
    @(posedge sys_clk_i);
    #1;
    spi_frame_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### tb/query_readback_tb_top.sv
// Self-checking bench for the query readback block
`timescale 1ns/1ps
`default_nettype none
module query_readback_tb_top;
  import query_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] sn = 32'h0, hw = 32'h0, fw = 32'h0;
  logic [7:0] yr = 8'h0, mo = 8'h0, dy = 8'h0, hr = 8'h0;
  logic [15:0] dac = 16'h0;
  wire logic cv, cl, rq, fr, bv, urv, sov, urs, srs;
  wire logic [7:0] cb, ce, sb, urb, sob;
  wire logic [10:0] lix;
  wire logic [39:0] lfq;
  int mismatches = 0;
  int tests_run = 0;
  logic [7:0] uq[$];
  logic [7:0] sq[$];
  logic [39:0] v;
  logic [15:0] ix;
  logic [2:0] s;

  always #5 sys_clk_i = ~sys_clk_i;

  function automatic logic [39:0] lf(input logic [10:0] i);
    return {5'h1A, i, 13'h0ABC, i};
  endfunction

  function automatic logic [39:0] exp_id(input logic [2:0] k);
    case (k)
      SEL_SERIAL: return {sn, 8'h00};
      SEL_HW_REV: return {hw, 8'h00};
      SEL_FW_REV: return {fw, 8'h00};
      SEL_MFG_DATE: return {yr, mo, dy, hr, 8'h00};
      default: return RESULT_RESET;
    endcase
  endfunction

  assign lfq = lf(lix);

  host_model i_host (.sys_clk_i(sys_clk_i), .usb_cmd_valid_o(cv), .usb_cmd_byte_o(cb), .usb_cmd_last_o(cl),
    .usb_cmd_endpoint_o(ce), .usb_rd_req_o(rq), .spi_frame_o(fr), .spi_byte_valid_o(bv), .spi_byte_o(sb));

  query_readback i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .usb_cmd_valid_i(cv), .usb_cmd_byte_i(cb),
    .usb_cmd_last_i(cl), .usb_cmd_endpoint_i(ce), .usb_rd_req_i(rq), .usb_rd_valid_o(urv), .usb_rd_byte_o(urb),
    .spi_frame_i(fr), .spi_byte_valid_i(bv), .spi_byte_i(sb), .spi_out_byte_o(sob), .spi_out_valid_o(sov),
    .serial_number_i(sn), .hw_revision_i(hw), .fw_revision_i(fw), .mfg_year_i(yr), .mfg_month_i(mo),
    .mfg_day_i(dy), .mfg_hour_i(hr), .level_dac_i(dac), .list_index_o(lix), .list_freq_i(lfq),
    .usb_result_valid_o(urs), .spi_result_valid_o(srs));

  // Collect answered bytes where they are settled
  always @(negedge sys_clk_i) begin
    if (urv === 1'b1) uq.push_back(urb);
    if (sov === 1'b1) sq.push_back(sob);
  end

  // ***********************
  // Checks
  // ***********************
  task automatic cmp40(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp40({39'h0, got}, {39'h0, exp});
  endtask

  // Exactly five answered bytes assemble into one readback word
  task automatic take(input bit spi, output logic [39:0] w);
    repeat (3) @(posedge sys_clk_i);
    w = 40'h0;
    for (int i = 0; i < RESULT_BYTES; i++) begin
      if (spi) w = {w[31:0], (sq.size() > 0) ? sq.pop_front() : 8'hxx};
      else w = {w[31:0], (uq.size() > 0) ? uq.pop_front() : 8'hxx};
    end
    cmp1(uq.size() == 0 && sq.size() == 0, 1'b1);
    uq.delete();
    sq.delete();
  endtask

  task automatic usb_read5(output logic [39:0] w);
    repeat (RESULT_BYTES) i_host.usb_read();
    take(1'b0, w);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #900000;
    mismatches++;
    wrap_up();
  end

  // ***********************
  // Scenarios
  // ***********************
  initial begin
    void'($urandom(86));
    sn = $urandom;
    hw = $urandom;
    fw = $urandom;
    {yr, mo, dy, hr} = $urandom;
    dac = $urandom;
    repeat (20) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    cmp1(urs, 1'b0);
    usb_read5(v);
    cmp40(v, RESULT_RESET);
    for (int k = 0; k < 5; k++) begin
      i_host.usb_cmd(BULK_OUT_ENDPOINT, ADDR_IDENTITY_QUERY, 40'(k), 1);
      @(posedge sys_clk_i);
      #1;
      cmp1(urs, 1'b1);
      usb_read5(v);
      cmp40(v, exp_id(3'(k)));
    end
    for (int k = 0; k < 6; k++) begin
      ix = (k == 0) ? 16'h0000 : (k == 1) ? 16'h07FF : 16'($urandom_range(0, 2047));
      i_host.usb_cmd(BULK_OUT_ENDPOINT, ADDR_LIST_POINT_QUERY, {24'h0, ix}, 2);
      usb_read5(v);
      cmp40(v, lf(ix[10:0]));
    end
    i_host.usb_cmd(BULK_OUT_ENDPOINT, ADDR_LEVEL_DAC_QUERY, 40'h0, 1);
    usb_read5(v);
    cmp40(v, {dac, 24'h0});
    i_host.usb_cmd(INTERRUPT_OUT_ENDPOINT, ADDR_IDENTITY_QUERY, 40'h0, 1);
    usb_read5(v);
    cmp40(v, RESULT_RESET);
    s = 3'($urandom_range(0, 3));
    i_host.spi_cmd(ADDR_IDENTITY_QUERY, {37'h0, s}, 1);
    repeat (4) @(posedge sys_clk_i);
    cmp1(srs, 1'b1);
    cmp1(sq.size() == 0, 1'b1);
    i_host.spi_cmd(ADDR_SPI_READOUT_BUFFER, 40'h0, 5);
    take(1'b1, v);
    cmp40(v, exp_id(s));
    cmp1(srs, 1'b0);
    i_host.spi_cmd(ADDR_SPI_READOUT_BUFFER, 40'h0, 5);
    take(1'b1, v);
    cmp40(v, RESULT_RESET);
    ix = 16'($urandom_range(0, 2047));
    fork
      i_host.usb_cmd(BULK_OUT_ENDPOINT, ADDR_LIST_POINT_QUERY, {24'h0, ix}, 2);
      i_host.spi_cmd(ADDR_LEVEL_DAC_QUERY, 40'h0, 1);
    join
    repeat (4) @(posedge sys_clk_i);
    usb_read5(v);
    cmp40(v, lf(ix[10:0]));
    i_host.spi_cmd(ADDR_SPI_READOUT_BUFFER, 40'h0, 5);
    take(1'b1, v);
    cmp40(v, {dac, 24'h0});
    wrap_up();
  end
endmodule
`default_nettype wire

// ### verilog/query_readback.sv
// Register command parser and query readback for the USB and SPI command paths
// Overview of operation
// - Writing the identity query loads the chosen parameter into the output buffer.
// - USB results are readable immediately after the query write.
// - SPI results go to a serial output buffer, not the query transaction.
// - A readout buffer transaction shifts out the result and clears the buffer.
// - Three-bit selector: serial, hardware rev, firmware rev, manufacture date.
// - Identity result sits in bits 39:8, low byte zero.
// - Serial unsigned integer; revisions returned as float bit patterns.
// - Date packs year, month, day, hour from high to low byte.
// - List query takes a point index and returns a 40-bit frequency.
// - Level DAC value in bits 39:24, lower 24 bits zero.
// - Readout shifts out the result of the latest query 0x20 to 0x25.
// - USB and SPI paths accept commands at the same time.
// - USB path runs full speed with control, interrupt and bulk transfers.
// - Endpoints are interrupt IN 0x81, OUT 0x02, bulk IN 0x83, OUT 0x04.
// - Commands are two to six bytes; first byte is the register address.
// - Readback is returned only after the previous command has executed.
// - Readback is valid only after a query register write.
// - USB readback is five bytes, MSB first, trailing bytes zero.
`timescale 1ns/1ps
`default_nettype none
module query_readback
  import query_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // USB bulk OUT command bytes
  input wire logic usb_cmd_valid_i,
  input wire logic [7:0] usb_cmd_byte_i,
  input wire logic usb_cmd_last_i,
  input wire logic [7:0] usb_cmd_endpoint_i,
  // USB bulk IN readback bytes
  input wire logic usb_rd_req_i,
  output logic usb_rd_valid_o,
  output logic [7:0] usb_rd_byte_o,
  // SPI command bytes, frame marks the transaction
  input wire logic spi_frame_i,
  input wire logic spi_byte_valid_i,
  input wire logic [7:0] spi_byte_i,
  // SPI readback bytes
  output logic [7:0] spi_out_byte_o,
  output logic spi_out_valid_o,
  // Identity and level sources
  input wire logic [31:0] serial_number_i,
  input wire logic [31:0] hw_revision_i,
  input wire logic [31:0] fw_revision_i,
  input wire logic [7:0] mfg_year_i,
  input wire logic [7:0] mfg_month_i,
  input wire logic [7:0] mfg_day_i,
  input wire logic [7:0] mfg_hour_i,
  input wire logic [15:0] level_dac_i,
  // List point lookup
  output logic [10:0] list_index_o,
  input wire logic [39:0] list_freq_i,
  // Status
  output logic usb_result_valid_o,
  output logic spi_result_valid_o
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [2:0] usb_cnt;
    logic [7:0] usb_addr;
    logic [15:0] usb_arg;
    logic usb_exec;
    logic [39:0] usb_buf;
    logic usb_buf_ok;
    logic [2:0] usb_rd_cnt;
    logic usb_rd_valid;
    logic [7:0] usb_rd_byte;
    logic [2:0] spi_cnt;
    logic [7:0] spi_addr;
    logic [15:0] spi_arg;
    logic spi_exec;
    logic spi_frame_q;
    logic [39:0] spi_buf;
    logic spi_buf_ok;
    logic [39:0] spi_shift;
    logic [2:0] spi_out_cnt;
    logic [7:0] spi_out_byte;
    logic spi_out_valid;
    logic [10:0] list_index;
  } state_t;

  state_t s_q;
  state_t s_d;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic is_query(input logic [7:0] a);
    is_query = (a >= ADDR_QUERY_FIRST) && (a <= ADDR_LEVEL_DAC_QUERY);
  endfunction

  logic [7:0] exec_addr;
  logic [15:0] exec_arg;
  logic [39:0] result;
  logic usb_bulk;

  // The lookup index is shared; the SPI path executes when USB is idle
  assign exec_addr = s_q.usb_exec ? s_q.usb_addr : s_q.spi_addr;
  assign exec_arg = s_q.usb_exec ? s_q.usb_arg : s_q.spi_arg;
  // Control and interrupt traffic stays in the full speed endpoint front end; only bulk OUT carries commands
  assign usb_bulk = usb_cmd_endpoint_i == BULK_OUT_ENDPOINT;

  query_result_mux u_mux (
    .addr_i(exec_addr),
    .arg_i(exec_arg),
    .serial_number_i(serial_number_i),
    .hw_revision_i(hw_revision_i),
    .fw_revision_i(fw_revision_i),
    .mfg_year_i(mfg_year_i),
    .mfg_month_i(mfg_month_i),
    .mfg_day_i(mfg_day_i),
    .mfg_hour_i(mfg_hour_i),
    .level_dac_i(level_dac_i),
    .list_freq_i(list_freq_i),
    .result_o(result)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    s_d.usb_rd_valid = 1'b0;
    s_d.spi_out_valid = 1'b0;
    s_d.usb_exec = 1'b0;
    s_d.spi_frame_q = spi_frame_i;

    // USB command bytes: address first, then data MSB first
    if (usb_cmd_valid_i && usb_bulk) begin
      if (s_q.usb_cnt == CNT_RESET) begin
        s_d.usb_addr = usb_cmd_byte_i;
        s_d.usb_arg = 16'h0000;
      end else begin
        s_d.usb_arg = {s_d.usb_arg[7:0], usb_cmd_byte_i};
      end
      if (s_q.usb_cnt != 3'h7) begin
        s_d.usb_cnt = s_q.usb_cnt + 3'h1;
      end
      if (usb_cmd_last_i) begin
        s_d.usb_cnt = CNT_RESET;
        s_d.usb_exec = 1'b1;
      end
    end
    if (s_q.usb_exec && is_query(s_q.usb_addr)) begin
      s_d.usb_buf = result;
      s_d.usb_buf_ok = 1'b1;
      s_d.usb_rd_cnt = CNT_RESET;
    end

    // USB readback, five bytes MSB first, zero once exhausted
    if (usb_rd_req_i && !s_q.usb_exec && !s_d.usb_exec) begin
      s_d.usb_rd_valid = 1'b1;
      s_d.usb_rd_byte = s_q.usb_buf_ok ? s_q.usb_buf[39:32] : 8'h00;
      s_d.usb_buf = {s_q.usb_buf[31:0], 8'h00};
      if (s_q.usb_rd_cnt != RESULT_BYTES_CNT) begin
        s_d.usb_rd_cnt = s_q.usb_rd_cnt + 3'h1;
      end
    end

    // SPI command bytes, parallel to USB
    if (spi_frame_i && !s_q.spi_frame_q) begin
      s_d.spi_cnt = CNT_RESET;
      s_d.spi_out_cnt = CNT_RESET;
    end
    if (spi_frame_i && spi_byte_valid_i) begin
      if (s_q.spi_cnt == CNT_RESET) begin
        s_d.spi_addr = spi_byte_i;
        s_d.spi_arg = 16'h0000;
        if (spi_byte_i == ADDR_SPI_READOUT_BUFFER) begin
          s_d.spi_shift = s_q.spi_buf_ok ? s_q.spi_buf : RESULT_RESET;
          s_d.spi_buf = RESULT_RESET;
          s_d.spi_buf_ok = 1'b0;
        end
      end else begin
        s_d.spi_arg = {s_q.spi_arg[7:0], spi_byte_i};
        if (s_q.spi_addr == ADDR_SPI_READOUT_BUFFER) begin
          if (s_q.spi_out_cnt != RESULT_BYTES_CNT) begin
            s_d.spi_out_byte = s_q.spi_shift[39:32];
            s_d.spi_out_valid = 1'b1;
            s_d.spi_shift = {s_q.spi_shift[31:0], 8'h00};
            s_d.spi_out_cnt = s_q.spi_out_cnt + 3'h1;
          end
        end
      end
      if (s_q.spi_cnt != 3'h7) begin
        s_d.spi_cnt = s_q.spi_cnt + 3'h1;
      end
    end
    if (!spi_frame_i && s_q.spi_frame_q && s_q.spi_cnt != CNT_RESET) begin
      s_d.spi_exec = 1'b1;
    end
    if (s_q.spi_exec && !s_q.usb_exec) begin
      s_d.spi_exec = 1'b0;
      if (is_query(s_q.spi_addr)) begin
        s_d.spi_buf = result;
        s_d.spi_buf_ok = 1'b1;
      end
    end

    if (s_d.usb_exec) begin
      s_d.list_index = s_d.usb_arg[10:0];
    end else begin
      s_d.list_index = s_d.spi_arg[10:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign usb_rd_valid_o = s_q.usb_rd_valid;
  assign usb_rd_byte_o = s_q.usb_rd_byte;
  assign spi_out_byte_o = s_q.spi_out_byte;
  assign spi_out_valid_o = s_q.spi_out_valid;
  assign list_index_o = s_q.list_index;
  assign usb_result_valid_o = s_q.usb_buf_ok;
  assign spi_result_valid_o = s_q.spi_buf_ok;

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_usb_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.usb_exec && is_query(s_q.usb_addr)) |=> (s_q.usb_buf_ok && s_q.usb_rd_cnt == CNT_RESET);
  endproperty
  a_usb_load: assert property (p_usb_load) else $error("usb query did not load buffer");

  property p_usb_first_byte;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (usb_rd_req_i && !s_q.usb_exec && !s_d.usb_exec && !s_q.usb_buf_ok) |=> (usb_rd_byte_o == 8'h00);
  endproperty
  a_usb_first_byte: assert property (p_usb_first_byte) else $error("readback before query not zero");

  property p_spi_clear;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (spi_frame_i && spi_byte_valid_i && s_q.spi_cnt == CNT_RESET && spi_byte_i == ADDR_SPI_READOUT_BUFFER)
      |=> (!spi_result_valid_o && s_q.spi_buf == RESULT_RESET);
  endproperty
  a_spi_clear: assert property (p_spi_clear) else $error("readout did not clear buffer");

  property p_spi_load;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.spi_exec && !s_q.usb_exec && is_query(s_q.spi_addr)) |=> spi_result_valid_o;
  endproperty
  a_spi_load: assert property (p_spi_load) else $error("spi query not buffered");

  property p_dac_low_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.usb_exec && s_q.usb_addr == ADDR_LEVEL_DAC_QUERY) |=> (s_q.usb_buf[23:0] == 24'h00_0000);
  endproperty
  a_dac_low_zero: assert property (p_dac_low_zero) else $error("dac low bits not zero");

  property p_ident_low_zero;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      (s_q.usb_exec && s_q.usb_addr == ADDR_IDENTITY_QUERY) |=> (s_q.usb_buf[7:0] == 8'h00);
  endproperty
  a_ident_low_zero: assert property (p_ident_low_zero) else $error("identity low byte not zero");

  property p_usb_wait_exec;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      s_q.usb_exec |=> !usb_rd_valid_o;
  endproperty
  a_usb_wait_exec: assert property (p_usb_wait_exec) else $error("readback during execution");

  property p_spi_out_bound;
    @(posedge sys_clk_i) disable iff (!rst_n_i)
      spi_out_valid_o |-> (s_q.spi_out_cnt != CNT_RESET && s_q.spi_addr == ADDR_SPI_READOUT_BUFFER);
  endproperty
  a_spi_out_bound: assert property (p_spi_out_bound) else $error("spi byte outside readout");

endmodule
`default_nettype wire

// ### verilog/query_result_mux.sv
// Combinational selection of the 40-bit query result from a decoded command
`timescale 1ns/1ps
`default_nettype none
module query_result_mux
  import query_pkg::*;
(
  // Decoded command
  input wire logic [7:0] addr_i,
  input wire logic [15:0] arg_i,
  // Identity and level sources
  input wire logic [31:0] serial_number_i,
  input wire logic [31:0] hw_revision_i,
  input wire logic [31:0] fw_revision_i,
  input wire logic [7:0] mfg_year_i,
  input wire logic [7:0] mfg_month_i,
  input wire logic [7:0] mfg_day_i,
  input wire logic [7:0] mfg_hour_i,
  input wire logic [15:0] level_dac_i,
  // List point data, one index looked up
  input wire logic [39:0] list_freq_i,
  // Result
  output logic [39:0] result_o
);

  logic [31:0] ident;

  always_comb begin
    unique case (arg_i[2:0])
      SEL_SERIAL: ident = serial_number_i;
      SEL_HW_REV: ident = hw_revision_i;
      SEL_FW_REV: ident = fw_revision_i;
      SEL_MFG_DATE: ident = {mfg_year_i, mfg_month_i, mfg_day_i, mfg_hour_i};
      default: ident = 32'h0000_0000;
    endcase
  end

  always_comb begin
    unique case (addr_i)
      ADDR_IDENTITY_QUERY: result_o = {ident, 8'h00};
      ADDR_LIST_POINT_QUERY: result_o = list_freq_i;
      ADDR_LEVEL_DAC_QUERY: result_o = {level_dac_i, 24'h00_0000};
      default: result_o = RESULT_RESET;
    endcase
  end

endmodule
`default_nettype wire
